// ==== design/dpr_pkg.sv ====
// Purpose: Shared constants and helpers for the dual-port cell array
// Assumes: One system clock at 125 MHz samples both user ports
// Notes:   Cell numbers run 0..4095, low address maps to low cells
package dpr_pkg;
    localparam int CELLS         = 4096;
    localparam int CELL_AW       = 12;
    localparam int MAX_W         = 16;
    localparam int SLICE_BITS    = 256;
    localparam int SLICES        = 16;
    localparam int SLICE_HEX     = 64;
    localparam int CLK_PERIOD_PS = 8000;
    // Cross-port window, least time in ps; plain default
    localparam int CROSS_PORT_WINDOW_PS = 8000;
    localparam int WIN_RAW  = (CROSS_PORT_WINDOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WIN_CYC  = (WIN_RAW < 1) ? 1 : WIN_RAW;
    localparam int AGE_BITS = 8;
    localparam logic [AGE_BITS-1:0] AGE_IDLE = 8'hFF;
    localparam logic [AGE_BITS-1:0] WIN_LAST = AGE_BITS'(WIN_CYC - 1);

    function automatic bit width_ok(input int w);
        return (w == 1) || (w == 2) || (w == 4) || (w == 8) || (w == 16);
    endfunction : width_ok

    function automatic int addr_bits(input int w);
        return CELL_AW - $clog2(w);
    endfunction : addr_bits

    function automatic logic [CELL_AW-1:0] cell_base(input logic [CELL_AW-1:0] a, input int w);
        return CELL_AW'(a * w);
    endfunction : cell_base

    // Invalid bits become unknown so later use of them shows
    function automatic logic [MAX_W-1:0] poison_bits(input logic [MAX_W-1:0] d,
                                                     input logic [MAX_W-1:0] m);
        logic [MAX_W-1:0] r;
        r = d;
        for (int i = 0; i < MAX_W; i++) begin
            if (m[i]) r[i] = 1'bx;
        end
        return r;
    endfunction : poison_bits

    // Bits of my word that fall inside the other port's word
    function automatic logic [MAX_W-1:0] overlap_mask(input logic [CELL_AW-1:0] mb, input int mw,
                                                      input logic [CELL_AW-1:0] ob, input int ow);
        logic [MAX_W-1:0] m;
        logic [CELL_AW:0]  c;
        m = '0;
        for (int i = 0; i < MAX_W; i++) begin
            c    = (CELL_AW+1)'(mb) + (CELL_AW+1)'(i);
            m[i] = (i < mw) && (c >= (CELL_AW+1)'(ob))
                   && (c < (CELL_AW+1)'(ob) + (CELL_AW+1)'(ow));
        end
        return m;
    endfunction : overlap_mask
endpackage : dpr_pkg

// ==== design/dpr_port_if.sv ====
// Purpose: One user port between the control logic and the cell array
// Assumes: Signals are qualified by fire, one system clock cycle long
// Notes:   poison marks bits stored as unknown, bad marks bits read as unknown
`timescale 1ns/10ps
`default_nettype none
interface dpr_port_if #(
    parameter int W  = 1,
    parameter int AW = 12
);
    logic          fire;
    logic          we;
    logic          clr;
    logic [AW-1:0] addr;
    logic [W-1:0]  wdata;
    logic [W-1:0]  poison;
    logic [W-1:0]  bad;
    logic [W-1:0]  rdata;

    modport ctl (output fire, we, clr, addr, wdata, poison, bad, input rdata);
    modport mem (input fire, we, clr, addr, wdata, poison, bad, output rdata);
endinterface : dpr_port_if
`default_nettype wire

// ==== design/dpr_cell_array.sv ====
// Purpose: 4096-cell array with two ports of own width and read-out registers
// Assumes: Port events come qualified and synchronous to clk
// Notes:   Array has no reset; contents come from the preload image
`timescale 1ns/10ps
`default_nettype none
module dpr_cell_array #(
    parameter int                        WA      = 1,
    parameter int                        WB      = 1,
    parameter logic [dpr_pkg::CELLS-1:0] PRELOAD = '0
) (
    input  wire logic clk,      // System clock
    input  wire logic reset_n,  // Async reset, read-out registers only
    dpr_port_if.mem   pa,       // Port A
    dpr_port_if.mem   pb        // Port B
);
    logic [dpr_pkg::CELLS-1:0]   cells = PRELOAD;
    logic [dpr_pkg::CELL_AW-1:0] a_base;
    logic [dpr_pkg::CELL_AW-1:0] b_base;
    logic [dpr_pkg::MAX_W-1:0]   a_wval;
    logic [dpr_pkg::MAX_W-1:0]   b_wval;
    logic [dpr_pkg::MAX_W-1:0]   a_rval;
    logic [dpr_pkg::MAX_W-1:0]   b_rval;
    logic [WA-1:0]               a_out_r;
    logic [WB-1:0]               b_out_r;

    assign a_base = dpr_pkg::cell_base(dpr_pkg::CELL_AW'(pa.addr), WA);
    assign b_base = dpr_pkg::cell_base(dpr_pkg::CELL_AW'(pb.addr), WB);
    assign a_wval = dpr_pkg::poison_bits(dpr_pkg::MAX_W'(pa.wdata), dpr_pkg::MAX_W'(pa.poison));
    assign b_wval = dpr_pkg::poison_bits(dpr_pkg::MAX_W'(pb.wdata), dpr_pkg::MAX_W'(pb.poison));
    assign a_rval = dpr_pkg::poison_bits(dpr_pkg::MAX_W'(cells[a_base +: WA]),
                                         dpr_pkg::MAX_W'(pa.bad));
    assign b_rval = dpr_pkg::poison_bits(dpr_pkg::MAX_W'(cells[b_base +: WB]),
                                         dpr_pkg::MAX_W'(pb.bad));

    // Both ports write the one shared array, no arbitration
    always_ff @(posedge clk) begin
        if (pa.fire && pa.we) cells[a_base +: WA] <= a_wval[WA-1:0];
        if (pb.fire && pb.we) cells[b_base +: WB] <= b_wval[WB-1:0];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            a_out_r <= '0;
        end else if (pa.fire) begin
            if (pa.clr)     a_out_r <= '0;
            else if (pa.we) a_out_r <= pa.wdata;
            else            a_out_r <= a_rval[WA-1:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            b_out_r <= '0;
        end else if (pb.fire) begin
            if (pb.clr)     b_out_r <= '0;
            else if (pb.we) b_out_r <= pb.wdata;
            else            b_out_r <= b_rval[WB-1:0];
        end
    end

    assign pa.rdata = a_out_r;
    assign pb.rdata = b_out_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    read_data_a: assert property (pa.fire && !pa.we && !pa.clr && pa.bad == '0
        |=> a_out_r === $past(cells[a_base +: WA]))
        else $error("port A read-out differs from addressed cells");
endmodule : dpr_cell_array
`default_nettype wire

// ==== design/dpr_dual_ram.sv ====
// Purpose: True dual-port 4096-bit RAM, each port with own clock pin and width
// Assumes: Port pins are asynchronous to mclk and slower than mclk by margin
// Notes:   Port pins pass two flops; a port edge is seen two to three mclk later
//
// How it works
// - Both ports share one array of 4096 single-bit cells.
// - Address A of a W-wide port selects cells A*W up to A*W+W-1.
// - Top address is 4095/2047/1023/511/255 for widths 1/2/4/8/16.
// - Same-cell access needs no arbitration and never harms other cells.
// - The window matters only for a shared cell with a write involved.
// - Two writes of one cell inside the window leave it invalid.
// - Write beside read in window: write succeeds, reader output invalid.
// - Each port samples its pins on its own clock rising edge.
// - Select high, write low: read addressed cells onto read-out.
// - Select and write high: store write-in and mirror it out.
// - Select low: nothing happens, read-out holds.
// - Read-out ignores the other port's writes until own next access.
// - Reading a cell written earlier outside the window returns new data.
// - Write-write: each port shows own data; cell later reads invalid.
// - Array powers up from sixteen 256-bit preload slices.
// - Slice k fills cells 256*k up to 256*k+255.
// - Missing slices and short values load as zeros.
// - Output clear zeros the read-out register only.
// - Inactive select blocks write and clear as well.
// - Clock, select, write and clear polarity each set by parameter.
//
`timescale 1ns/10ps
`default_nettype none
module dpr_dual_ram #(
    parameter int                        WA          = 1,
    parameter int                        WB          = 1,
    parameter bit                        A_CLK_INV   = 1'b0,
    parameter bit                        A_SEL_INV   = 1'b0,
    parameter bit                        A_WR_INV    = 1'b0,
    parameter bit                        A_CLR_INV   = 1'b0,
    parameter bit                        B_CLK_INV   = 1'b0,
    parameter bit                        B_SEL_INV   = 1'b0,
    parameter bit                        B_WR_INV    = 1'b0,
    parameter bit                        B_CLR_INV   = 1'b0,
    // Slice k sits in bits 256*k+255 down to 256*k; unset slices stay zero
    parameter logic [dpr_pkg::CELLS-1:0] PRELOAD     = '0,
    parameter int                        AWA         = dpr_pkg::addr_bits(WA),
    parameter int                        AWB         = dpr_pkg::addr_bits(WB)
) (
    input  wire logic           mclk,             // System clock, 125 MHz
    input  wire logic           reset_n,          // Async reset, active low
    input  wire logic           port_a_clock,     // Port A clock pin
    input  wire logic           port_a_select,    // Port A enable
    input  wire logic           port_a_write,     // Port A write strobe
    input  wire logic           port_a_clear,     // Port A output clear
    input  wire logic [AWA-1:0] port_a_addr,      // Port A word address
    input  wire logic [WA-1:0]  port_a_write_in,  // Port A write data
    output logic      [WA-1:0]  port_a_read_out,  // Port A read-out register
    input  wire logic           port_b_clock,     // Port B clock pin
    input  wire logic           port_b_select,    // Port B enable
    input  wire logic           port_b_write,     // Port B write strobe
    input  wire logic           port_b_clear,     // Port B output clear
    input  wire logic [AWB-1:0] port_b_addr,      // Port B word address
    input  wire logic [WB-1:0]  port_b_write_in,  // Port B write data
    output logic      [WB-1:0]  port_b_read_out   // Port B read-out register
);
    localparam int SA = 4 + AWA + WA;
    localparam int SB = 4 + AWB + WB;

    if (!dpr_pkg::width_ok(WA) || !dpr_pkg::width_ok(WB)) begin : g_bad_width
        $error("port width must be 1, 2, 4, 8 or 16");
    end
    if (AWA != dpr_pkg::addr_bits(WA) || AWB != dpr_pkg::addr_bits(WB)) begin : g_bad_aw
        $error("address width must match port width");
    end

    dpr_port_if #(.W(WA), .AW(AWA)) pa ();
    dpr_port_if #(.W(WB), .AW(AWB)) pb ();

    logic [SA-1:0]                a_s1_r;
    logic [SA-1:0]                a_s2_r;
    logic                         a_clk_d_r;
    logic [SB-1:0]                b_s1_r;
    logic [SB-1:0]                b_s2_r;
    logic                         b_clk_d_r;
    logic                         a_clk;
    logic                         a_fire;
    logic                         a_we;
    logic                         a_clr;
    logic [AWA-1:0]               a_addr;
    logic [WA-1:0]                a_data;
    logic                         b_clk;
    logic                         b_fire;
    logic                         b_we;
    logic                         b_clr;
    logic [AWB-1:0]               b_addr;
    logic [WB-1:0]                b_data;
    logic [dpr_pkg::CELL_AW-1:0]  a_base;
    logic [dpr_pkg::CELL_AW-1:0]  b_base;
    logic [dpr_pkg::CELL_AW-1:0]  a_wbase_r;
    logic [dpr_pkg::CELL_AW-1:0]  b_wbase_r;
    logic [dpr_pkg::AGE_BITS-1:0] a_age_r;
    logic [dpr_pkg::AGE_BITS-1:0] b_age_r;
    logic                         a_wr_now;
    logic                         b_wr_now;
    logic                         a_hot;
    logic                         b_hot;
    logic [dpr_pkg::CELL_AW-1:0]  a_hot_base;
    logic [dpr_pkg::CELL_AW-1:0]  b_hot_base;
    logic [dpr_pkg::MAX_W-1:0]    a_mask16;
    logic [dpr_pkg::MAX_W-1:0]    b_mask16;
    logic [WA-1:0]                a_mask;
    logic [WB-1:0]                b_mask;

    // Pin synchronisers, two flops each
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            a_s1_r <= '0;
            a_s2_r <= '0;
        end else begin
            a_s1_r <= {port_a_clock, port_a_select, port_a_write, port_a_clear,
                       port_a_addr, port_a_write_in};
            a_s2_r <= a_s1_r;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            b_s1_r <= '0;
            b_s2_r <= '0;
        end else begin
            b_s1_r <= {port_b_clock, port_b_select, port_b_write, port_b_clear,
                       port_b_addr, port_b_write_in};
            b_s2_r <= b_s1_r;
        end
    end

    // Preset high so no false edge shows right after reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            a_clk_d_r <= 1'b1;
            b_clk_d_r <= 1'b1;
        end else begin
            a_clk_d_r <= a_clk;
            b_clk_d_r <= b_clk;
        end
    end

    // Polarity applied after synchronising
    assign a_clk  = a_s2_r[SA-1] ^ A_CLK_INV;
    assign a_fire = a_clk && !a_clk_d_r && (a_s2_r[SA-2] ^ A_SEL_INV);
    assign a_we   = a_s2_r[SA-3] ^ A_WR_INV;
    assign a_clr  = a_s2_r[SA-4] ^ A_CLR_INV;
    assign a_addr = a_s2_r[WA +: AWA];
    assign a_data = a_s2_r[WA-1:0];

    assign b_clk  = b_s2_r[SB-1] ^ B_CLK_INV;
    assign b_fire = b_clk && !b_clk_d_r && (b_s2_r[SB-2] ^ B_SEL_INV);
    assign b_we   = b_s2_r[SB-3] ^ B_WR_INV;
    assign b_clr  = b_s2_r[SB-4] ^ B_CLR_INV;
    assign b_addr = b_s2_r[WB +: AWB];
    assign b_data = b_s2_r[WB-1:0];

    assign a_base   = dpr_pkg::cell_base(dpr_pkg::CELL_AW'(a_addr), WA);
    assign b_base   = dpr_pkg::cell_base(dpr_pkg::CELL_AW'(b_addr), WB);
    assign a_wr_now = a_fire && a_we;
    assign b_wr_now = b_fire && b_we;

    // Last write of each port and its age in mclk cycles
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            a_wbase_r <= '0;
            a_age_r   <= dpr_pkg::AGE_IDLE;
        end else if (a_wr_now) begin
            a_wbase_r <= a_base;
            a_age_r   <= '0;
        end else if (a_age_r != dpr_pkg::AGE_IDLE) begin
            a_age_r   <= a_age_r + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            b_wbase_r <= '0;
            b_age_r   <= dpr_pkg::AGE_IDLE;
        end else if (b_wr_now) begin
            b_wbase_r <= b_base;
            b_age_r   <= '0;
        end else if (b_age_r != dpr_pkg::AGE_IDLE) begin
            b_age_r   <= b_age_r + 1'b1;
        end
    end

    // A write of the other port still inside the window
    assign a_hot      = b_wr_now || (b_age_r < dpr_pkg::WIN_LAST);
    assign a_hot_base = b_wr_now ? b_base : b_wbase_r;
    assign b_hot      = a_wr_now || (a_age_r < dpr_pkg::WIN_LAST);
    assign b_hot_base = a_wr_now ? a_base : a_wbase_r;

    assign a_mask16 = a_hot ? dpr_pkg::overlap_mask(a_base, WA, a_hot_base, WB) : '0;
    assign b_mask16 = b_hot ? dpr_pkg::overlap_mask(b_base, WB, b_hot_base, WA) : '0;
    assign a_mask   = a_mask16[WA-1:0];
    assign b_mask   = b_mask16[WB-1:0];

    assign pa.fire   = a_fire;
    assign pa.we     = a_we;
    assign pa.clr    = a_clr;
    assign pa.addr   = a_addr;
    assign pa.wdata  = a_data;
    assign pa.poison = a_we ? a_mask : '0;
    assign pa.bad    = a_we ? '0 : a_mask;

    assign pb.fire   = b_fire;
    assign pb.we     = b_we;
    assign pb.clr    = b_clr;
    assign pb.addr   = b_addr;
    assign pb.wdata  = b_data;
    assign pb.poison = b_we ? b_mask : '0;
    assign pb.bad    = b_we ? '0 : b_mask;

    dpr_cell_array #(
        .WA      (WA),
        .WB      (WB),
        .PRELOAD (PRELOAD)
    ) u_array (
        .clk     (mclk),
        .reset_n (reset_n),
        .pa      (pa.mem),
        .pb      (pb.mem)
    );

    assign port_a_read_out = pa.rdata;
    assign port_b_read_out = pb.rdata;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    clear_zero_a: assert property (a_fire && a_clr |=> port_a_read_out == '0)
        else $error("port A clear did not zero read-out");

    write_mirror_a: assert property (a_fire && a_we && !a_clr
        |=> port_a_read_out == $past(a_data))
        else $error("port A write not mirrored on read-out");

    write_mirror_b: assert property (b_fire && b_we && !b_clr
        |=> port_b_read_out == $past(b_data))
        else $error("port B write not mirrored on read-out");

    // Case equality so an invalid read-out that holds still counts as held
    idle_hold_a: assert property (!a_fire |=> port_a_read_out === $past(port_a_read_out))
        else $error("port A read-out changed without access");

    idle_hold_b: assert property (a_wr_now && !b_fire
        |=> port_b_read_out === $past(port_b_read_out))
        else $error("port B read-out followed port A write");

    ww_poison_a: assert property (a_wr_now && b_wr_now && a_base == b_base
        |-> pa.poison[0] && pb.poison[0])
        else $error("same-cell double write not marked invalid");

    wr_bad_read_a: assert property (b_wr_now && a_fire && !a_we && a_base == b_base
        |-> pa.bad[0] && pb.poison == '0)
        else $error("read beside write not flagged invalid");

    // Disjoint cell ranges worked out apart from the mask function
    window_quiet_a: assert property (a_fire && b_wr_now
        && (int'(a_base) + WA <= int'(b_base) || int'(b_base) + WB <= int'(a_base))
        |-> a_mask == '0)
        else $error("conflict flagged without shared cell");

    later_clean_a: assert property (a_fire && !a_we && !b_wr_now
        && int'(b_age_r) >= dpr_pkg::WIN_CYC |-> pa.bad == '0)
        else $error("read outside window flagged invalid");

    rd_cov: cover property (a_fire && !a_we && !a_clr);
    wr_cov: cover property (b_wr_now ##[1:20] a_fire && !a_we);
    ww_cov: cover property (a_wr_now && b_wr_now && a_base == b_base);
    clr_cov: cover property (b_fire && b_clr);
endmodule : dpr_dual_ram
`default_nettype wire

// ==== test/dpr_user_port.sv ====
// Purpose: User logic on one RAM port, making its clock and control pins
// Assumes: Port clock phases span several mclk so the port synchroniser sees them
// Notes:   Released pins show the inverse of their last value
`timescale 1ns/10ps
`default_nettype none
module dpr_user_port #(
    parameter int W  = 1,
    parameter int AW = dpr_pkg::addr_bits(W)
) (
    input  wire logic          mclk,   // System clock
    output logic               pclk,   // Port clock pin
    output logic               sel,    // Port enable
    output logic               wr,     // Write strobe
    output logic               clr,    // Output clear
    output logic      [AW-1:0] addr,   // Word address
    output logic      [W-1:0]  wdata,  // Write data
    output logic               done    // Read-out settled, one cycle
);
    initial begin
        pclk  = 1'b0;
        sel   = 1'b0;
        wr    = 1'b0;
        clr   = 1'b0;
        addr  = '0;
        wdata = '0;
        done  = 1'b0;
    end

    // One access per call; the bench keeps ports apart outside conflict tests
    task automatic access(input logic s, w, c, input logic [AW-1:0] a, input logic [W-1:0] d);
        @(posedge mclk);
        sel   <= s;
        wr    <= w;
        clr   <= c;
        addr  <= a;
        wdata <= d;
        repeat (4) @(posedge mclk);
        pclk <= 1'b1;
        repeat (6) @(posedge mclk);
        done <= 1'b1;
        @(posedge mclk);
        done <= 1'b0;
        pclk <= 1'b0;
        repeat (3) @(posedge mclk);
        sel   <= ~s;
        wr    <= ~w;
        clr   <= ~c;
        addr  <= ~a;
        wdata <= ~d;
    endtask : access
endmodule : dpr_user_port
`default_nettype wire

// ==== test/dpr_dual_ram_bench.sv ====
// Purpose: Self-checking bench for the dual-port RAM
// Assumes: Port A 4 bits wide, port B 16 bits wide, default polarities
// Notes:   Expected read-outs are queued per port and checked on done
`timescale 1ns/10ps
`default_nettype none
module dpr_dual_ram_bench;
    localparam logic [4095:0] PRE = {16'hC3A5, 4064'h0, 16'h5A17};
    logic          mclk, reset_n, a_clk, a_sel, a_wr, a_clr, b_clk, b_sel, b_wr, b_clr;
    logic          done_a, done_b;
    logic [9:0]    a_addr;
    logic [3:0]    a_wd, a_rd, last_a;
    logic [7:0]    b_addr;
    logic [15:0]   b_wd, b_rd, last_b;
    logic [4095:0] mem_ref;
    logic [3:0]    qa[$];
    logic [15:0]   qb[$];
    logic [31:0]   seed;
    int            n_errors, n_tests, cycles;

    dpr_dual_ram #(.WA(4), .WB(16), .PRELOAD(PRE)) dpr_dual_ram_i (
        .mclk(mclk), .reset_n(reset_n), .port_a_clock(a_clk), .port_a_select(a_sel),
        .port_a_write(a_wr), .port_a_clear(a_clr), .port_a_addr(a_addr),
        .port_a_write_in(a_wd), .port_a_read_out(a_rd), .port_b_clock(b_clk),
        .port_b_select(b_sel), .port_b_write(b_wr), .port_b_clear(b_clr),
        .port_b_addr(b_addr), .port_b_write_in(b_wd), .port_b_read_out(b_rd));
    dpr_user_port #(.W(4)) dpr_user_port_a_i (.mclk(mclk), .pclk(a_clk),
        .sel(a_sel), .wr(a_wr), .clr(a_clr), .addr(a_addr), .wdata(a_wd), .done(done_a));
    dpr_user_port #(.W(16)) dpr_user_port_b_i (.mclk(mclk), .pclk(b_clk),
        .sel(b_sel), .wr(b_wr), .clr(b_clr), .addr(b_addr), .wdata(b_wd), .done(done_b));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic acc_a(input logic s, w, c, input logic [9:0] a, input logic [3:0] d);
        if (s && w) mem_ref[a*4 +: 4] = d;
        if (s) last_a = c ? 4'h0 : mem_ref[a*4 +: 4];
        qa.push_back(last_a);
    endtask : acc_a

    task automatic acc_b(input logic s, w, c, input logic [7:0] a, input logic [15:0] d);
        if (s && w) mem_ref[a*16 +: 16] = d;
        if (s) last_b = c ? 16'h0 : mem_ref[a*16 +: 16];
        qb.push_back(last_b);
    endtask : acc_b

    task automatic run_a(input logic s, w, c, input logic [9:0] a, input logic [3:0] d);
        acc_a(s, w, c, a, d);
        dpr_user_port_a_i.access(s, w, c, a, d);
    endtask : run_a

    task automatic run_b(input logic s, w, c, input logic [7:0] a, input logic [15:0] d);
        acc_b(s, w, c, a, d);
        dpr_user_port_b_i.access(s, w, c, a, d);
    endtask : run_b

    always @(posedge mclk) begin
        if (done_a === 1'b1) check({12'h0, a_rd}, {12'h0, qa.pop_front()}, "port A");
        if (done_b === 1'b1) check(b_rd, qb.pop_front(), "port B");
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_errors++;
            report_and_stop();
        end
    end

    initial begin
        reset_n = 1'b0;
        n_errors = 0;
        n_tests = 0;
        cycles = 0;
        seed = 32'h00015566;
        mem_ref = PRE;
        last_a = 4'h0;
        last_b = 16'h0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        check({12'h0, a_rd}, 16'h0, "A after reset");
        check(b_rd, 16'h0, "B after reset");
        run_b(1, 0, 0, 8'h00, 16'hFFFF);
        run_b(1, 0, 0, 8'hFF, 16'h0);
        run_b(1, 0, 0, 8'h64, 16'h0);
        run_a(1, 0, 0, 10'h001, 4'h0);
        run_a(1, 0, 0, 10'h3FF, 4'h0);
        $display("test preload done");
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            run_a(1, 1, 0, seed[9:0], seed[13:10]);
            run_b(1, 0, 0, seed[9:2], seed[31:16]);
            run_b(1, 1, 0, seed[25:18], seed[31:16]);
            run_a(1, 0, 0, {seed[25:18], seed[1:0]}, seed[7:4]);
        end
        $display("test random cross done");
        run_a(1, 0, 0, 10'h004, 4'h0);
        run_b(1, 1, 0, 8'h01, 16'hBEEF);
        run_a(0, 1, 1, 10'h004, 4'h5);
        run_a(1, 0, 0, 10'h004, 4'h0);
        run_b(1, 1, 1, 8'h02, 16'h1357);
        run_b(1, 0, 0, 8'h02, 16'h0);
        run_a(1, 0, 1, 10'h008, 4'h0);
        $display("test hold and clear done");
        acc_a(1, 1, 0, 10'h000, 4'hA);
        acc_b(1, 1, 0, 8'h00, 16'h1234);
        mem_ref[3:0] = 'x;
        fork
            dpr_user_port_a_i.access(1, 1, 0, 10'h000, 4'hA);
            dpr_user_port_b_i.access(1, 1, 0, 8'h00, 16'h1234);
        join
        run_a(1, 0, 0, 10'h000, 4'h0);
        run_b(1, 0, 0, 8'h00, 16'h0);
        acc_a(1, 1, 0, 10'h001, 4'h6);
        last_b = mem_ref[15:0];
        last_b[7:4] = 'x;
        qb.push_back(last_b);
        fork
            dpr_user_port_a_i.access(1, 1, 0, 10'h001, 4'h6);
            dpr_user_port_b_i.access(1, 0, 0, 8'h00, 16'h0);
        join
        run_a(1, 0, 0, 10'h001, 4'h0);
        acc_a(1, 1, 0, 10'h010, 4'h9);
        acc_b(1, 1, 0, 8'h05, 16'h2468);
        fork
            dpr_user_port_a_i.access(1, 1, 0, 10'h010, 4'h9);
            dpr_user_port_b_i.access(1, 1, 0, 8'h05, 16'h2468);
        join
        run_a(1, 0, 0, 10'h010, 4'h0);
        run_b(1, 0, 0, 8'h05, 16'h0);
        acc_b(1, 1, 0, 8'h03, 16'h4321);
        last_a = 4'hx;
        qa.push_back(last_a);
        fork
            dpr_user_port_a_i.access(1, 0, 0, 10'h00C, 4'h0);
            dpr_user_port_b_i.access(1, 1, 0, 8'h03, 16'h4321);
        join
        run_a(1, 0, 0, 10'h00C, 4'h0);
        $display("test conflicts done");
        report_and_stop();
    end
endmodule : dpr_dual_ram_bench
`default_nettype wire
